// *** src/t3pb_pkg.sv ***
// Behaviour
// - Counter moves only while the run enable bit is one; otherwise it holds.
// - Non-stop, no reload: count to zero, then load 0x3ff and keep counting.
// - Non-stop with reload: on underflow load the 10-bit reload value.
// - One-shot: count once from the initial value to zero, then stop.
// - High-oscillator select set: timer and PWM run from the high oscillator.
// - High-oscillator select clear: clock source follows the source select bit.
// - Source select one picks the external pin, zero the instruction clock.
// - External clock: falling edge counts when edge bit is one, else rising.
// - Polarity bit one drives the PWM active low, zero active high.
// - PWM enable routes the waveform to the shared pin, else plain GPIO.
// - Prescaler divides by two to the power of select plus one.
// - Prescaler enable is active low: zero uses it, one bypasses it.
// - High oscillator and extend bit set: duty grows by half a clock; the code holds the output one more pclk cycle instead.
// - Frame period from the 10-bit reload, duty from a separate 10-bit value.
// - Reading the prescaler count register returns the live prescaler count.
// - Buzzer codes 0-7 take prescaler taps, codes 8-15 timer bits 0-7.
// - Buzzer output runs only while the buzzer enable bit is one.
// - Count register write loads reload and counter from byte plus high bits.
// - External clock comes in on a shared port A pin.
package t3pb_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_COUNT = 6'h10;
   localparam logic [5:0] IDX_CTL1 = 6'h11;
   localparam logic [5:0] IDX_CTL2 = 6'h12;
   localparam logic [5:0] IDX_DUTY = 6'h13;
   localparam logic [5:0] IDX_PSCV = 6'h14;
   localparam logic [5:0] IDX_BUZZ = 6'h15;
   localparam logic [5:0] IDX_HIGH = 6'h16;
   // Control one fields
   localparam int C1_RUN = 0;
   localparam int C1_RELOAD = 1;
   localparam int C1_ONESHOT = 2;
   localparam int C1_HOSC = 3;
   localparam int C1_ACTLOW = 6;
   localparam int C1_PWMEN = 7;
   localparam logic [7:0] C1_MASK = 8'hcf;
   // Control two fields
   localparam int C2_SEL_LSB = 0;
   localparam int C2_PSDIS_N = 3;
   localparam int C2_EDGE = 4;
   localparam int C2_EXTSRC = 5;
   localparam int C2_HALFEXT = 6;
   localparam logic [7:0] C2_READ_MASK = 8'h3f;
   // Buzzer control and high bits
   localparam int BZ_EN = 7;
   localparam logic [7:0] BZ_MASK = 8'h8f;
   localparam int HI_PER_LSB = 4;
   localparam int HI_DUTY_LSB = 0;
   localparam logic [7:0] HI_MASK = 8'h33;
   // Values after reset, then the no-reload wrap value
   localparam logic [7:0] RST_CTL1 = 8'h00;
   localparam logic [7:0] RST_CTL2 = 8'h3f;
   localparam logic [7:0] RST_BUZZ = 8'h0f;
   localparam logic [7:0] RST_PSCV = 8'hff;
   localparam logic [9:0] WRAP_VALUE = 10'h3ff;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } t3pb_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } t3pb_apb_rsp_t;
endpackage : t3pb_pkg

// *** src/t3pb_timer.sv ***
// Chosen here: register access over APB.
`timescale 1ns/1ps
module t3pb_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire t3pb_pkg::t3pb_apb_req_t apb_req,
   output t3pb_pkg::t3pb_apb_rsp_t apb_rsp,
   input wire logic instr_tick,
   input wire logic hosc_tick,
   input wire logic port_a_pin_one_i,
   input wire logic gpio_a2_out,
   input wire logic gpio_a2_oe,
   output logic port_a_pin_two_o,
   output logic port_a_pin_two_oe,
   output logic buzzer_o
);
   import t3pb_pkg::*;

   typedef struct packed {
      logic [7:0] ctl1;
      logic [7:0] ctl2;
      logic [7:0] duty_lo;
      logic [7:0] buzz;
      logic [7:0] high;
      logic [9:0] cnt;
      logic [9:0] rld;
      logic [7:0] ps;
      logic stop;
      logic ext_s1;
      logic ext_s2;
      logic ext_s3;
      logic raw_q;
      logic pwm_q;
      logic buzz_q;
      logic [31:0] prdata;
      logic perr;
   } t3pb_state_t;

   t3pb_state_t q;
   t3pb_state_t d;

   logic setup;
   logic wr;
   logic hit;
   logic [7:0] rdval;
   logic [5:0] idx;
   logic ext_edge;
   logic src_tick;
   logic [7:0] ps_mask;
   logic pre_tick;
   logic tick;
   logic wr_count;
   logic [9:0] duty10;
   logic [9:0] elapsed;
   logic raw;
   logic tap;

   assign idx = apb_req.paddr[7:2];
   assign setup = apb_req.psel & ~apb_req.penable;
   // Freezing the clock enable also stalls the bus, so no write is lost
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & ce;
   assign wr_count = wr & (idx == IDX_COUNT);

   always_comb begin
      hit = 1'b1;
      case (idx)
         IDX_COUNT: rdval = q.cnt[7:0];
         IDX_CTL1: rdval = q.ctl1;
         IDX_CTL2: rdval = q.ctl2 & C2_READ_MASK;
         IDX_PSCV: rdval = q.ps;
         IDX_HIGH: rdval = q.high;
         IDX_DUTY: rdval = 8'h00;
         IDX_BUZZ: rdval = 8'h00;
         default: begin
            rdval = 8'h00;
            hit = 1'b0;
         end
      endcase
   end

   // Edge found on the second and third stages, never the first
   assign ext_edge = q.ctl2[C2_EDGE] ? (q.ext_s3 & ~q.ext_s2)
                                     : (~q.ext_s3 & q.ext_s2);

   always_comb begin
      if (q.ctl1[C1_HOSC]) begin
         src_tick = hosc_tick;
      end else if (q.ctl2[C2_EXTSRC]) begin
         src_tick = ext_edge;
      end else begin
         src_tick = instr_tick;
      end
   end

   // Low select-plus-one bits all ones marks the divided tick
   assign ps_mask = 8'((9'h002 << q.ctl2[C2_SEL_LSB +: 3]) - 9'h001);
   assign pre_tick = src_tick & ((q.ps & ps_mask) == ps_mask);
   assign tick = q.ctl2[C2_PSDIS_N] ? src_tick : pre_tick;

   assign duty10 = {q.high[HI_DUTY_LSB +: 2], q.duty_lo};
   assign elapsed = q.rld - q.cnt;
   assign raw = elapsed < duty10;

   assign tap = q.buzz[3] ? q.cnt[q.buzz[2:0]] : q.ps[q.buzz[2:0]];

   always_comb begin
      d = q;
      d.ext_s1 = port_a_pin_one_i;
      d.ext_s2 = q.ext_s1;
      d.ext_s3 = q.ext_s2;
      if (setup) begin
         d.prdata = {24'h000000, rdval};
         d.perr = ~hit;
      end
      if (wr) begin
         case (idx)
            IDX_CTL1: d.ctl1 = apb_req.pwdata[7:0] & C1_MASK;
            IDX_CTL2: d.ctl2 = apb_req.pwdata[7:0] & 8'h7f;
            IDX_DUTY: d.duty_lo = apb_req.pwdata[7:0];
            IDX_BUZZ: d.buzz = apb_req.pwdata[7:0] & BZ_MASK;
            IDX_HIGH: d.high = apb_req.pwdata[7:0] & HI_MASK;
            default: d.perr = q.perr;
         endcase
      end
      if (src_tick && !q.ctl2[C2_PSDIS_N]) begin
         d.ps = q.ps + 8'h01;
      end
      if (wr_count) begin
         d.rld = {q.high[HI_PER_LSB +: 2], apb_req.pwdata[7:0]};
         d.cnt = {q.high[HI_PER_LSB +: 2], apb_req.pwdata[7:0]};
         d.stop = 1'b0;
      end else if (tick && q.ctl1[C1_RUN] && !q.stop) begin
         if (q.cnt != 10'h000) begin
            d.cnt = q.cnt - 10'h001;
         end else if (q.ctl1[C1_ONESHOT]) begin
            d.stop = 1'b1;
         end else if (q.ctl1[C1_RELOAD]) begin
            d.cnt = q.rld;
         end else begin
            d.cnt = WRAP_VALUE;
         end
      end
      d.raw_q = raw;
      // Half-clock stretch approximated by holding one more pclk cycle
      d.pwm_q = (raw | (q.ctl1[C1_HOSC] & q.ctl2[C2_HALFEXT] & q.raw_q))
                ^ q.ctl1[C1_ACTLOW];
      d.buzz_q = q.buzz[BZ_EN] & tap;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctl1 <= RST_CTL1;
         q.ctl2 <= RST_CTL2;
         q.buzz <= RST_BUZZ;
         q.ps <= RST_PSCV;
      end else if (ce) begin
         q <= d;
      end
   end

   assign apb_rsp.pready = ce;
   assign apb_rsp.prdata = q.prdata;
   assign apb_rsp.pslverr = q.perr;
   assign port_a_pin_two_o = q.ctl1[C1_PWMEN] ? q.pwm_q : gpio_a2_out;
   assign port_a_pin_two_oe = q.ctl1[C1_PWMEN] | gpio_a2_oe;
   assign buzzer_o = q.buzz_q;

   logic quiet;
   assign quiet = ce & ~wr_count;

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (quiet && !q.ctl1[C1_RUN]) |=> (q.cnt == $past(q.cnt));
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved while stopped");

   property p_dec;
      @(posedge pclk) disable iff (!presetn)
      (quiet && tick && q.ctl1[C1_RUN] && !q.stop && q.cnt != 10'h000)
      |=> (q.cnt == $past(q.cnt) - 10'h001);
   endproperty
   a_dec: assert property (p_dec) else $error("counter did not step down");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      (quiet && tick && q.ctl1[C1_RUN] && !q.stop && q.cnt == 10'h000
       && !q.ctl1[C1_ONESHOT] && !q.ctl1[C1_RELOAD]) |=> (q.cnt == 10'h3ff);
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap to 0x3ff");

   property p_reload;
      @(posedge pclk) disable iff (!presetn)
      (quiet && tick && q.ctl1[C1_RUN] && !q.stop && q.cnt == 10'h000
       && !q.ctl1[C1_ONESHOT] && q.ctl1[C1_RELOAD]) |=> (q.cnt == $past(q.rld));
   endproperty
   a_reload: assert property (p_reload) else $error("reload value not loaded");

   property p_oneshot;
      @(posedge pclk) disable iff (!presetn)
      (quiet && tick && q.ctl1[C1_RUN] && q.cnt == 10'h000 && q.ctl1[C1_ONESHOT])
      |=> (q.stop && q.cnt == 10'h000);
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot kept counting");

   property p_load;
      @(posedge pclk) disable iff (!presetn)
      wr_count |=> (q.cnt == q.rld && q.cnt[7:0] == $past(apb_req.pwdata[7:0]));
   endproperty
   a_load: assert property (p_load) else $error("count write not loaded");

   property p_gpio;
      @(posedge pclk) disable iff (!presetn)
      !q.ctl1[C1_PWMEN] |-> (port_a_pin_two_o == gpio_a2_out
                              && port_a_pin_two_oe == gpio_a2_oe);
   endproperty
   a_gpio: assert property (p_gpio) else $error("pin not left to GPIO");

   property p_buzz_off;
      @(posedge pclk) disable iff (!presetn)
      (ce && !q.buzz[BZ_EN]) |=> !buzzer_o;
   endproperty
   a_buzz_off: assert property (p_buzz_off) else $error("buzzer on while disabled");

   property p_pscv;
      @(posedge pclk) disable iff (!presetn)
      (ce && setup && idx == IDX_PSCV) |=> (apb_rsp.prdata[7:0] == $past(q.ps));
   endproperty
   a_pscv: assert property (p_pscv) else $error("prescaler read wrong");

   property p_polarity;
      @(posedge pclk) disable iff (!presetn)
      (ce && !q.ctl2[C2_HALFEXT]) |=>
      (q.pwm_q == ($past(raw) ^ $past(q.ctl1[C1_ACTLOW])));
   endproperty
   a_polarity: assert property (p_polarity) else $error("PWM polarity wrong");

   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      (ce && q.ctl2[C2_PSDIS_N]) |=> (q.ps == $past(q.ps));
   endproperty
   a_bypass: assert property (p_bypass) else $error("prescaler ran while off");

   property p_stop_hold;
      @(posedge pclk) disable iff (!presetn)
      (quiet && q.stop) |=> (q.cnt == 10'h000);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

   property p_hosc_src;
      @(posedge pclk) disable iff (!presetn)
      q.ctl1[C1_HOSC] |-> (src_tick == hosc_tick);
   endproperty
   a_hosc_src: assert property (p_hosc_src) else $error("high osc not used");

   property p_instr_src;
      @(posedge pclk) disable iff (!presetn)
      (!q.ctl1[C1_HOSC] && !q.ctl2[C2_EXTSRC]) |-> (src_tick == instr_tick);
   endproperty
   a_instr_src: assert property (p_instr_src) else $error("instr clock not used");

   // Edges are judged from the synchroniser, never from the raw pin
   property p_ext_rise;
      @(posedge pclk) disable iff (!presetn)
      (!q.ctl1[C1_HOSC] && q.ctl2[C2_EXTSRC] && !q.ctl2[C2_EDGE]
       && q.ext_s2 && !q.ext_s3) |-> src_tick;
   endproperty
   a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge missed");

   property p_ext_fall;
      @(posedge pclk) disable iff (!presetn)
      (!q.ctl1[C1_HOSC] && q.ctl2[C2_EXTSRC] && q.ctl2[C2_EDGE]
       && !q.ext_s2 && q.ext_s3) |-> src_tick;
   endproperty
   a_ext_fall: assert property (p_ext_fall) else $error("falling pin edge missed");

   property p_div_full;
      @(posedge pclk) disable iff (!presetn)
      (!q.ctl2[C2_PSDIS_N] && q.ctl2[C2_SEL_LSB +: 3] == 3'h7 && tick)
      |-> (q.ps == 8'hff);
   endproperty
   a_div_full: assert property (p_div_full) else $error("divide by 256 wrong");

   property p_extend;
      @(posedge pclk) disable iff (!presetn)
      (ce && q.ctl1[C1_HOSC] && q.ctl2[C2_HALFEXT] && q.raw_q)
      |=> (q.pwm_q != $past(q.ctl1[C1_ACTLOW]));
   endproperty
   a_extend: assert property (p_extend) else $error("duty not extended");

   property p_pwm_pin;
      @(posedge pclk) disable iff (!presetn)
      q.ctl1[C1_PWMEN] |-> (port_a_pin_two_o == q.pwm_q && port_a_pin_two_oe);
   endproperty
   a_pwm_pin: assert property (p_pwm_pin) else $error("PWM not on pin");

   // At frame start the output is active exactly when the duty is nonzero
   property p_frame_start;
      @(posedge pclk) disable iff (!presetn)
      (q.rld == q.cnt) |-> (raw == (duty10 != 10'h000));
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame start wrong");

   property p_tap_cnt;
      @(posedge pclk) disable iff (!presetn)
      (ce && q.buzz[BZ_EN] && q.buzz[3]) |=> (buzzer_o == $past(q.cnt[q.buzz[2:0]]));
   endproperty
   a_tap_cnt: assert property (p_tap_cnt) else $error("buzzer timer tap wrong");

   property p_tap_ps;
      @(posedge pclk) disable iff (!presetn)
      (ce && q.buzz[BZ_EN] && !q.buzz[3]) |=> (buzzer_o == $past(q.ps[q.buzz[2:0]]));
   endproperty
   a_tap_ps: assert property (p_tap_ps) else $error("buzzer prescaler tap wrong");
endmodule : t3pb_timer

// *** test/timer3_pwm3_buzzer3_tb.sv ***
`timescale 1ns/1ps
module timer3_pwm3_buzzer3_tb;
   import t3pb_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic e;} t3pb_row_t;
   logic pclk, presetn, ce, instr_tick, hosc_tick, pin1, gpio_out, gpio_oe;
   logic pin2, pin2_oe, buzz, rerr;
   logic [7:0] rdata;
   t3pb_apb_req_t req;
   t3pb_apb_rsp_t rsp;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   // Address, value after reset, slave error; the last row is unmapped
   t3pb_row_t rows[8] = '{'{8'h40, 8'h00, 1'b0}, '{8'h44, 8'h00, 1'b0}, '{8'h48, 8'h3f, 1'b0},
      '{8'h4c, 8'h00, 1'b0}, '{8'h50, 8'hff, 1'b0}, '{8'h54, 8'h00, 1'b0},
      '{8'h58, 8'h00, 1'b0}, '{8'h5c, 8'h00, 1'b1}};
   // Prescaler count 0x07 below, timer count 0xa5 above
   logic [15:0] taps = 16'ha507;

   t3pb_timer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp),
      .instr_tick(instr_tick), .hosc_tick(hosc_tick), .port_a_pin_one_i(pin1),
      .gpio_a2_out(gpio_out), .gpio_a2_oe(gpio_oe), .port_a_pin_two_o(pin2),
      .port_a_pin_two_oe(pin2_oe), .buzzer_o(buzz));

   task stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      rdata = rsp.prdata[7:0];
      rerr = rsp.pslverr;
      req <= '0;
      if (n >= 50) begin
         n_fail++;
         $display("Error apb ready expected 1 seen 0");
      end
   endtask : apb

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      apb(1'b0, a, 8'h00);
      chk(nm, exp, rdata);
   endtask : rd

   // Source 0 instruction tick, 1 high oscillator tick, 2 pin toggle
   task pulse(input int src, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (src == 0) instr_tick <= 1'b1;
         else if (src == 1) hosc_tick <= 1'b1;
         else pin1 <= ~pin1;
         @(posedge pclk);
         instr_tick <= 1'b0;
         hosc_tick <= 1'b0;
         // Pin edges need the synchroniser to settle
         repeat (4) @(posedge pclk);
      end
   endtask : pulse

   // One high oscillator tick, then the pin one and two cycles later
   task hosc_step(input logic [7:0] e1, input logic [7:0] e2, input string nm);
      @(posedge pclk);
      hosc_tick <= 1'b1;
      @(posedge pclk);
      hosc_tick <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk(nm, e1, {6'h0, pin2_oe, pin2});
      @(negedge pclk);
      chk(nm, e2, {6'h0, pin2_oe, pin2});
   endtask : hosc_step

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         $display("Error run time expected below 20000 seen 20000");
         stop_test();
      end
   end

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      instr_tick = 1'b0;
      hosc_tick = 1'b0;
      pin1 = 1'b0;
      gpio_out = 1'b1;
      gpio_oe = 1'b0;
      req = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 8'h00);
         chk("reset read", rows[i].d, rdata);
         chk("slave error", {7'h0, rows[i].e}, {7'h0, rerr});
      end
      $display("test reset done");
      wr(8'h48, 8'h08);
      wr(8'h40, 8'h05);
      wr(8'h44, 8'h01);
      pulse(0, 6);
      rd(8'h40, 8'hff, "wrap count");
      wr(8'h40, 8'h05);
      wr(8'h44, 8'h03);
      pulse(0, 6);
      rd(8'h40, 8'h05, "reload count");
      wr(8'h44, 8'h05);
      wr(8'h40, 8'h03);
      pulse(0, 5);
      rd(8'h40, 8'h00, "one shot count");
      wr(8'h44, 8'h00);
      wr(8'h40, 8'h09);
      pulse(0, 3);
      rd(8'h40, 8'h09, "held count");
      wr(8'h44, 8'h09);
      pulse(0, 3);
      pulse(1, 2);
      rd(8'h40, 8'h07, "hosc count");
      $display("test modes done");
      wr(8'h44, 8'h01);
      wr(8'h48, 8'h28);
      pulse(2, 3);
      rd(8'h40, 8'h05, "rising pin count");
      wr(8'h48, 8'h38);
      pulse(2, 1);
      rd(8'h40, 8'h04, "falling pin count");
      $display("test pin done");
      // Rate is changed only with the prescaler disabled
      wr(8'h48, 8'h08);
      wr(8'h48, 8'h00);
      pulse(0, 4);
      rd(8'h40, 8'h02, "div2 count");
      rd(8'h50, 8'h03, "prescaler value");
      wr(8'h48, 8'h09);
      wr(8'h48, 8'h01);
      pulse(0, 4);
      rd(8'h40, 8'h01, "div4 count");
      wr(8'h48, 8'h08);
      $display("test prescaler done");
      wr(8'h44, 8'h00);
      wr(8'h40, 8'ha5);
      for (int k = 0; k < 16; k++) begin
         wr(8'h54, 8'h80 | 8'(k));
         repeat (3) @(posedge pclk);
         chk("buzzer tap", {7'h0, taps[k]}, {7'h0, buzz});
      end
      wr(8'h54, 8'h0f);
      repeat (3) @(posedge pclk);
      chk("buzzer off", 8'h00, {7'h0, buzz});
      $display("test buzzer done");
      chk("gpio pin", 8'h01, {6'h0, pin2_oe, pin2});
      wr(8'h58, 8'h03);
      wr(8'h4c, 8'hff);
      wr(8'h40, 8'h05);
      wr(8'h44, 8'hc0);
      repeat (3) @(posedge pclk);
      chk("pwm low full", 8'h02, {6'h0, pin2_oe, pin2});
      wr(8'h44, 8'h80);
      repeat (3) @(posedge pclk);
      chk("pwm high full", 8'h03, {6'h0, pin2_oe, pin2});
      wr(8'h58, 8'h00);
      wr(8'h4c, 8'h00);
      repeat (3) @(posedge pclk);
      chk("pwm zero duty", 8'h02, {6'h0, pin2_oe, pin2});
      $display("test pwm done");
      wr(8'h4c, 8'h01);
      wr(8'h48, 8'h48);
      wr(8'h44, 8'h89);
      wr(8'h40, 8'h05);
      hosc_step(8'h03, 8'h02, "pwm extended");
      wr(8'h48, 8'h08);
      wr(8'h40, 8'h05);
      hosc_step(8'h02, 8'h02, "pwm plain");
      wr(8'h44, 8'h01);
      wr(8'h40, 8'h05);
      @(posedge pclk);
      ce <= 1'b0;
      pulse(0, 3);
      chk("stall ready", 8'h00, {7'h0, rsp.pready});
      @(posedge pclk);
      ce <= 1'b1;
      rd(8'h40, 8'h05, "frozen count");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h44, 8'h00, "ctl1 after reset");
      rd(8'h50, 8'hff, "prescaler after reset");
      $display("test awkward done");
      stop_test();
   end
endmodule : timer3_pwm3_buzzer3_tb
